/* File: logic/fsm_regs.vh */
`ifndef FSM_REGS_VH
`define FSM_REGS_VH
// operation codes on op_code
`define FSM_OP_W        3
`define FSM_OP_NONE     3'h0
`define FSM_OP_HALF_ST  3'h1
`define FSM_OP_WORD_ST  3'h2
`define FSM_OP_STAT_ST  3'h3
`define FSM_OP_TO_ACC   3'h4
`define FSM_OP_ABS_ST   3'h5
`define FSM_OP_ABS_LD   3'h6
// host status first register flag positions
`define FSM_ST_ZERO_BIT 1
`define FSM_ST_NEG_BIT  2
// cycles taken by the absolute-address moves
`define FSM_ABS_CYCLES  2
`endif

/* File: logic/fsm_flag_calc.v */
`timescale 1ns/1ns
`default_nettype none
module fsm_flag_calc #(
    parameter W = 32
) (
    input  wire [W-1:0] value,
    output wire         zero,
    output wire         negative
);
    assign zero     = (value == {W{1'b0}});
    assign negative = value[W-1];
endmodule // fsm_flag_calc
`default_nettype wire

/* File: logic/fsm_store_moves.v */
`timescale 1ns/1ns
`default_nettype none
`include "fsm_regs.vh"
module fsm_store_moves #(
    parameter W = 32
) (
    input  wire                 clock,
    input  wire                 reset,
    input  wire                 op_valid,
    input  wire [`FSM_OP_W-1:0] op_code,
    input  wire [15:0]          abs_address,
    input  wire [W-1:0]         fp_source_reg,
    input  wire [W-1:0]         fp_status_register,
    input  wire [W-1:0]         general_location_word,
    input  wire                 dest_is_accumulator,
    input  wire [W-1:0]         mem_read_data,
    output wire                 op_ready,
    output reg  [31:0]          mem_address,
    output reg                  mem_write,
    output reg                  mem_write_half,
    output reg                  mem_read,
    output reg  [W-1:0]         mem_write_data,
    output reg                  acc_write,
    output reg  [W-1:0]         integer_accumulator,
    output reg                  loc_write,
    output reg  [W-1:0]         general_location_out,
    output reg                  host_status_write,
    output reg                  host_status_zero,
    output reg                  host_status_neg,
    output reg                  done
);
    localparam S_IDLE = 3'h1;
    localparam S_LD   = 3'h2;
    localparam S_ST   = 3'h4;

    reg  [2:0]   state_q;
    reg  [2:0]   state_d;
    reg          to_acc_q;
    wire         ld_zero;
    wire         ld_neg;
    wire [31:0]  ext_addr;
    wire [W-1:0] half_data;
    genvar       g;

    // zero_extended_absolute_address
    assign ext_addr = {16'h0000, abs_address};
    // new op accepted only when idle; stalls during two-cycle moves
    assign op_ready = state_q[0];

    // half store data, upper bits zero-filled
    generate
        for (g = 0; g < W; g = g + 1) begin : g_half
            if (g < 16) begin : g_lo
                assign half_data[g] = fp_source_reg[g];
            end else begin : g_hi
                assign half_data[g] = 1'b0;
            end
        end
    endgenerate

    fsm_flag_calc #(
        .W (W)
    ) u_flags (
        .value    (mem_read_data),
        .zero     (ld_zero),
        .negative (ld_neg)
    );

    // only the two-cycle moves leave idle
    always @* begin
        state_d = S_IDLE;
        case (state_q)
            S_IDLE: begin
                if (op_valid && op_code == `FSM_OP_ABS_LD)
                    state_d = S_LD;
                else if (op_valid && op_code == `FSM_OP_ABS_ST)
                    state_d = S_ST;
            end

            // load result taken, back to idle
            S_LD: begin
                state_d = S_IDLE;
            end

            // write strobe issued, back to idle
            S_ST: begin
                state_d = S_IDLE;
            end

            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // outputs registered; address and data hold between ops
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q              <= S_IDLE;
            to_acc_q             <= 1'b0;

            mem_address          <= 32'h0000_0000;
            mem_write            <= 1'b0;
            mem_write_half       <= 1'b0;
            mem_read             <= 1'b0;
            mem_write_data       <= {W{1'b0}};

            acc_write            <= 1'b0;
            integer_accumulator  <= {W{1'b0}};
            loc_write            <= 1'b0;
            general_location_out <= {W{1'b0}};

            host_status_write    <= 1'b0;
            host_status_zero     <= 1'b0;
            host_status_neg      <= 1'b0;
            done                 <= 1'b0;
        end else begin
            state_q           <= state_d;

            // strobes default low: each is a one-cycle pulse
            mem_write         <= 1'b0;
            mem_write_half    <= 1'b0;
            mem_read          <= 1'b0;
            acc_write         <= 1'b0;
            loc_write         <= 1'b0;
            host_status_write <= 1'b0;
            done              <= 1'b0;
            // fp status flags never touched: block has no path to them
            if (state_q == S_IDLE && op_valid) begin
                case (op_code)
                    `FSM_OP_HALF_ST: begin
                        mem_write      <= 1'b1;
                        mem_write_half <= 1'b1;
                        mem_address    <= ext_addr;
                        mem_write_data <= half_data;
                        done           <= 1'b1;
                    end

                    `FSM_OP_WORD_ST: begin
                        mem_write      <= 1'b1;
                        mem_address    <= ext_addr;
                        mem_write_data <= fp_source_reg;
                        done           <= 1'b1;
                    end

                    `FSM_OP_STAT_ST: begin
                        mem_write      <= 1'b1;
                        mem_address    <= ext_addr;
                        mem_write_data <= fp_status_register;
                        done           <= 1'b1;
                    end

                    `FSM_OP_TO_ACC: begin
                        // full copy
                        // alignment before the copy is the host's job
                        acc_write           <= 1'b1;
                        integer_accumulator <= fp_source_reg;
                        done                <= 1'b1;
                    end

                    `FSM_OP_ABS_ST: begin
                        mem_address    <= ext_addr;
                        mem_write_data <= general_location_word;
                    end

                    `FSM_OP_ABS_LD: begin
                        mem_read    <= 1'b1;
                        mem_address <= ext_addr;
                        // destination latched; inputs may move on
                        to_acc_q    <= dest_is_accumulator;
                    end

                    default: begin
                        done <= 1'b0;
                    end
                endcase
            end

            // second cycle of the absolute store
            if (state_q == S_ST) begin
                mem_write <= 1'b1;
                done      <= 1'b1;
            end

            if (state_q == S_LD) begin
                done <= 1'b1;
                if (to_acc_q) begin
                    acc_write           <= 1'b1;
                    integer_accumulator <= mem_read_data;
                    host_status_write   <= 1'b1;
                    host_status_zero    <= ld_zero;
                    host_status_neg     <= ld_neg;
                end else begin
                    loc_write            <= 1'b1;
                    general_location_out <= mem_read_data;
                end
            end
        end
    end
endmodule // fsm_store_moves
`default_nettype wire

/* File: verif/fsm_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fsm_mem_model (
    input  wire logic        clock,
    input  wire logic        mem_write,
    input  wire logic        mem_read,
    input  wire logic [31:0] mem_address,
    input  wire logic [31:0] mem_write_data,
    output var  logic [31:0] mem_read_data
);
    logic [31:0] mem [0:15];
    initial for (int i = 0; i < 16; i++) mem[i] = 32'h0;
    logic [31:0] junk = 32'h5a5a_a5a5;
    // data stands while the strobe is high, junk otherwise
    always @(posedge clock) begin
        if (mem_write) mem[mem_address[15:12]] <= mem_write_data;
        junk <= ~junk;
    end
    always_comb
        mem_read_data = mem_read ? mem[mem_address[15:12]] : junk;
endmodule // fsm_mem_model
`default_nettype wire

/* File: verif/fsm_store_moves_sva.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fsm_regs.vh"
module fsm_store_moves_sva (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        op_valid,
    input wire logic [2:0]  op_code,
    input wire logic [15:0] abs_address,
    input wire logic [31:0] fp_source_reg,
    input wire logic        op_ready,
    input wire logic [31:0] mem_address,
    input wire logic        mem_write,
    input wire logic        mem_read,
    input wire logic [31:0] mem_write_data,
    input wire logic [31:0] integer_accumulator,
    input wire logic        done
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire logic [2:0] tk = (op_valid && op_ready) ? op_code : 3'h0;
    property p_half; tk == `FSM_OP_HALF_ST |=>
        mem_write_data == {16'h0, $past(fp_source_reg[15:0])}; endproperty
    a_half: assert property (p_half) else $error("half data");
    property p_word; tk == `FSM_OP_WORD_ST |=>
        mem_write && mem_write_data == $past(fp_source_reg); endproperty
    a_word: assert property (p_word) else $error("word data");
    property p_acc; tk == `FSM_OP_TO_ACC |=>
        integer_accumulator == $past(fp_source_reg); endproperty
    a_acc: assert property (p_acc) else $error("acc copy");
    property p_one; tk == `FSM_OP_STAT_ST |=> done && op_ready; endproperty
    a_one: assert property (p_one) else $error("stat cycles");
    property p_abst; tk == `FSM_OP_ABS_ST |=> !mem_write ##1 mem_write &&
        mem_address == {16'h0, $past(abs_address, 2)}; endproperty
    a_abst: assert property (p_abst) else $error("abs store");
    property p_absl; tk == `FSM_OP_ABS_LD |=>
        mem_read && !op_ready ##1 done; endproperty
    a_absl: assert property (p_absl) else $error("abs load");
    property p_gap; $fell(op_ready) |=> op_ready; endproperty
    a_gap: assert property (p_gap) else $error("gap length");
    property p_rd; mem_read |->
        mem_address == {16'h0, $past(abs_address)}; endproperty
    a_rd: assert property (p_rd) else $error("load address");
endmodule // fsm_store_moves_sva
`default_nettype wire

/* File: verif/test_fsm_store_moves.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fsm_regs.vh"
module test_fsm_store_moves;
    logic        clock, reset, op_valid, dest_is_accumulator;
    logic [2:0]  op_code;
    logic [15:0] abs_address;
    logic [31:0] fp_source_reg, fp_status_register, general_location_word;
    wire  [31:0] mem_read_data, mem_address, mem_write_data;
    wire  [31:0] integer_accumulator, general_location_out;
    wire         op_ready, mem_write, mem_read, host_status_zero;
    wire         host_status_neg, done, mem_write_half, acc_write;
    wire         loc_write, host_status_write;
    int          err_count, n_tests, lat;
    fsm_store_moves uut (.clock, .reset, .op_valid, .op_code, .abs_address,
        .fp_source_reg, .fp_status_register, .general_location_word,
        .dest_is_accumulator, .mem_read_data, .op_ready, .mem_address,
        .mem_write, .mem_write_half, .mem_read, .mem_write_data,
        .acc_write, .integer_accumulator, .loc_write,
        .general_location_out, .host_status_write, .host_status_zero,
        .host_status_neg, .done);
    fsm_mem_model mem (.clock, .mem_write, .mem_read, .mem_address,
        .mem_write_data, .mem_read_data);
    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask
    task stop_test;
        $display("mismatches %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // bounded wait for done, counts cycles after the take edge
    task go(input logic [2:0] op, input logic [15:0] a, input logic [31:0] v);
        @(posedge clock) op_valid <= 1'h1;
        {op_code, abs_address, fp_source_reg} <= {op, a, v};
        {general_location_word, fp_status_register} <= {v, ~v};
        @(posedge clock) op_valid <= 1'h0;
        #1 lat = 1;
        while (done !== 1'h1 && lat < 5) begin
            @(posedge clock) #1 lat++;
        end
        if (done !== 1'h1) begin
            err_count++;
            stop_test;
        end
    endtask
    task s_stores;
        go(`FSM_OP_HALF_ST, 16'hf00d, 32'h89abcdef);
        chk(mem_write_data, 32'h0000cdef);
        chk({mem_write, mem_write_half}, 2'h3);
        chk(mem_address, 32'h0000f00d);
        go(`FSM_OP_STAT_ST, 16'h0004, 32'h89abcdef);
        chk(mem_write_data, 32'h76543210);
        chk(lat, 1);
        go(`FSM_OP_WORD_ST, 16'h0008, 32'h89abcdef);
        chk(mem_write_data, 32'h89abcdef);
        chk({mem_write, mem_write_half}, 2'h2);
        chk(lat, 1);
        // go leaves an idle cycle before the copy
        go(`FSM_OP_TO_ACC, 16'h0004, 32'h0f0f1234);
        chk(integer_accumulator, 32'h0f0f1234);
        chk({acc_write, mem_write}, 2'h2);
    endtask
    task ld(input logic [15:0] a, input logic d, input logic [31:0] e,
            input logic [1:0] f);
        @(posedge clock) dest_is_accumulator <= d;
        go(`FSM_OP_ABS_LD, a, 32'h0);
        chk(lat, 2);
        chk(d ? integer_accumulator : general_location_out, e);
        chk({acc_write, loc_write, host_status_write}, {d, !d, d});
        chk({host_status_zero, host_status_neg}, f);
    endtask
    task s_abs;
        go(`FSM_OP_ABS_ST, 16'ha000, 32'h1234abcd);
        chk(mem_address, 32'h0000a000);
        chk(mem_write_data, 32'h1234abcd);
        chk(mem_write, 1);
        chk(lat, 2);
        go(`FSM_OP_ABS_ST, 16'hb000, 32'h80000001);
        ld(16'ha000, 1'h1, 32'h1234abcd, 2'h0);
        ld(16'hb000, 1'h1, 32'h80000001, 2'h1);
        ld(16'hc000, 1'h1, 32'h0, 2'h2);
        ld(16'ha000, 1'h0, 32'h1234abcd, 2'h2);
    endtask
    initial begin
        {reset, op_valid, dest_is_accumulator, op_code} = 6'h20;
        {abs_address, fp_source_reg} = 48'h0;
        {fp_status_register, general_location_word} = 64'h0;
        repeat (8) @(posedge clock);
        reset <= 1'h0;
        s_stores;
        s_abs;
        stop_test;
    end
endmodule // test_fsm_store_moves
bind fsm_store_moves fsm_store_moves_sva u_sva (.clock, .reset, .op_valid,
    .op_code, .abs_address, .fp_source_reg, .op_ready, .mem_address,
    .mem_write, .mem_read, .mem_write_data, .integer_accumulator, .done);
`default_nettype wire
